// *** rtl/sdo_pkg.sv ***
// Purpose: Shared constants and types for the segmented data object store.
// Assumes: One tag-structured file, single-byte tags, lengths up to 64 bytes.
// Notes:   Status words are 16 bits, first status byte in the upper half.

package sdo_pkg;

   // ==========================================================
   // Store geometry
   localparam int          NSLOT        = 4;
   localparam int          SLOT_DEPTH   = 64;
   localparam logic [15:0] SLOT_LEN_MAX = 16'(SLOT_DEPTH);
   localparam logic [16:0] CAP_BYTES    = 17'h00080;

   // ==========================================================
   // Command field values
   localparam logic [7:0]  TAG_MIN      = 8'h01;
   localparam logic [7:0]  TAG_MAX      = 8'hFE;
   localparam logic [4:0]  TAG_MULTI    = 5'h1F;
   localparam logic [7:0]  LEN_LONG     = 8'h80;
   localparam logic [7:0]  LEN_FORM1    = 8'h81;
   localparam logic [7:0]  LEN_FORM2    = 8'h82;
   localparam logic [7:0]  P1_ZERO      = 8'h00;
   localparam logic [4:0]  SFI_CURRENT  = 5'h00;
   localparam logic [1:0]  BLK_FIRST    = 2'b10;
   localparam logic [1:0]  BLK_NEXT     = 2'b00;
   localparam logic [1:0]  BLK_RETX     = 2'b01;
   localparam logic [1:0]  BLK_RFU      = 2'b11;

   // ==========================================================
   // Status words
   localparam logic [15:0] SW_NONE      = 16'h0000;
   localparam logic [15:0] SW_OK        = 16'h9000;
   localparam logic [15:0] SW_MORE      = 16'h63F1;
   localparam logic [15:0] SW_MORE_PRO  = 16'h63F2;
   localparam logic [15:0] SW_NOMEM     = 16'h6A84;
   localparam logic [15:0] SW_BADP2     = 16'h6A86;
   localparam logic [15:0] SW_WRONGLEN  = 16'h6700;
   localparam logic [15:0] SW_COND      = 16'h6985;
   localparam logic [15:0] SW_BADDATA   = 16'h6A80;
   localparam logic [15:0] SW_SEC       = 16'h6982;
   localparam logic [15:0] SW_BADP1     = 16'h6B00;
   localparam logic [15:0] SW_TECH      = 16'h6F00;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic       upd_ok;
      logic       mod_ef;
   } sdo_hdr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] tag;
   } sdo_ptr_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_TAG, ST_LEN0, ST_LEN1, ST_LEN2, ST_VAL, ST_SKIP, ST_DONE
   } sdo_st_t;

endpackage

// *** rtl/sdo_store.sv ***
// Purpose: Card-side handler for the segmented data object write command.
// Assumes: Header arrives first, then exactly lc data bytes of that command.
// Notes:   Summary of operation follows.

`timescale 1ns/1ps

module sdo_store
#(
   parameter logic [7:0] INS_SET_DATA = 8'h01,
   parameter logic [7:0] INS_GET_RESP = 8'h02
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Command header
   input  wire logic              cmd_valid,
   input  wire sdo_pkg::sdo_hdr_t cmd_hdr,
   output logic                   cmd_ready,
   // Command data bytes
   input  wire logic              dat_valid,
   input  wire logic [7:0]        dat_byte,
   // Context from the rest of the card
   input  wire sdo_pkg::sdo_ptr_t lock_other,
   input  wire logic              proactive_pending,
   input  wire logic              resp_offer,
   // Answer
   output logic                   sw_valid,
   output logic [15:0]            sw,
   output logic                   gr_grant,
   output sdo_pkg::sdo_ptr_t      own_ptr,
   // Readback
   input  wire logic [7:0]        rd_tag,
   input  wire logic [5:0]        rd_idx,
   output logic                   rd_hit,
   output logic [6:0]             rd_len,
   output logic [7:0]             rd_byte
);

   // ==========================================================
   // State
   sdo_pkg::sdo_st_t  st_r;
   sdo_pkg::sdo_st_t  st_nxt;
   sdo_pkg::sdo_hdr_t hdr_r;
   sdo_pkg::sdo_ptr_t ptr_r;
   logic [15:0]       res_r;
   logic [15:0]       res_nxt;
   logic [7:0]        rem_r;
   logic [7:0]        tag_r;
   logic [7:0]        vlen_r;
   logic [6:0]        off_r;
   logic [6:0]        prev_start_r;
   logic [7:0]        prev_lc_r;
   logic              prev_ok_r;
   logic              open_r;
   logic [1:0]        ptr_idx_r;
   logic              pend_r;
   logic [7:0]        used_r;
   logic              ready_r;
   logic              sw_valid_r;
   logic [15:0]       sw_r;
   logic              gr_grant_r;
   logic              rd_hit_r;
   logic [6:0]        rd_len_r;
   logic [7:0]        rd_byte_r;
   // Packed tables, so slot scans re-evaluate whenever any slot changes
   logic [sdo_pkg::NSLOT-1:0]      s_used_r;
   logic [sdo_pkg::NSLOT-1:0][7:0] s_tag_r;
   logic [sdo_pkg::NSLOT-1:0][6:0] s_len_r;
   logic [7:0]        mem_r    [sdo_pkg::NSLOT][sdo_pkg::SLOT_DEPTH];

   // Scan for a live slot holding tag t, or for the first empty slot
   // Tables come in as arguments; a hidden read would not retrigger the wires
   function automatic logic [2:0] find_slot(input logic free_only,
                                            input logic [7:0] t,
                                            input logic [sdo_pkg::NSLOT-1:0] u,
                                            input logic [sdo_pkg::NSLOT-1:0][7:0] tg);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < sdo_pkg::NSLOT; i++)
      begin
         if (!r[2] && (free_only ? !u[i] : (u[i] && tg[i] == t)))
         begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Header decode
   wire       acc      = cmd_valid && ready_r;
   wire       is_set   = cmd_hdr.ins == INS_SET_DATA;
   wire       is_gr    = cmd_hdr.ins == INS_GET_RESP;
   wire [1:0] blk      = cmd_hdr.p2[7:6];
   wire       sfi_bad  = blk != sdo_pkg::BLK_FIRST && cmd_hdr.p2[4:0] != sdo_pkg::SFI_CURRENT;
   wire [6:0] cur_len  = s_len_r[ptr_idx_r];
   wire [6:0] room     = cur_len - off_r;
   wire       last     = rem_r == 8'h01;
   wire       set_r    = hdr_r.ins == INS_SET_DATA;
   wire [1:0] blk_r    = hdr_r.p2[7:6];
   wire [15:0] more_sw = proactive_pending ? sdo_pkg::SW_MORE_PRO : sdo_pkg::SW_MORE;

   // Checks run in priority order; the first failure decides the word
   wire [15:0] hdr_sw =
      (cmd_hdr.p1 != sdo_pkg::P1_ZERO)                  ? sdo_pkg::SW_BADP1 :
      (!cmd_hdr.upd_ok)                                 ? sdo_pkg::SW_SEC :
      (blk == sdo_pkg::BLK_RFU || sfi_bad)              ? sdo_pkg::SW_BADP2 :
      (blk == sdo_pkg::BLK_NEXT && !open_r)             ? sdo_pkg::SW_BADP2 :
      (blk == sdo_pkg::BLK_RETX && !prev_ok_r)          ? sdo_pkg::SW_COND :
      (blk == sdo_pkg::BLK_RETX && cmd_hdr.lc != prev_lc_r) ? sdo_pkg::SW_COND :
      (blk == sdo_pkg::BLK_NEXT && cmd_hdr.lc > {1'b0, room}) ? sdo_pkg::SW_WRONGLEN :
      (blk == sdo_pkg::BLK_FIRST && cmd_hdr.lc == 8'h00) ? sdo_pkg::SW_WRONGLEN :
      sdo_pkg::SW_NONE;
   wire        hdr_ok  = acc && is_set && hdr_sw == sdo_pkg::SW_NONE;
   wire        retx_go = hdr_ok && blk == sdo_pkg::BLK_RETX;
   wire        next_go = hdr_ok && blk == sdo_pkg::BLK_NEXT;

   // ==========================================================
   // First block: tag and length parse
   wire in_tag  = dat_valid && st_r == sdo_pkg::ST_TAG;
   wire in_len0 = dat_valid && st_r == sdo_pkg::ST_LEN0;
   wire tag_bad = dat_byte < sdo_pkg::TAG_MIN || dat_byte > sdo_pkg::TAG_MAX
                  || dat_byte[4:0] == sdo_pkg::TAG_MULTI;
   wire lock_hit = lock_other.valid && lock_other.tag == dat_byte;
   wire [15:0] tag_sw = tag_bad  ? sdo_pkg::SW_BADDATA :
                        lock_hit ? sdo_pkg::SW_COND :
                        sdo_pkg::SW_NONE;
   wire len_done = (in_len0 && dat_byte < sdo_pkg::LEN_LONG)
                   || (dat_valid && st_r == sdo_pkg::ST_LEN2);
   wire len_more = (in_len0 && (dat_byte == sdo_pkg::LEN_FORM1
                   || dat_byte == sdo_pkg::LEN_FORM2))
                   || (dat_valid && st_r == sdo_pkg::ST_LEN1);
   wire len_bad  = in_len0 && dat_byte >= sdo_pkg::LEN_LONG && !len_more;
   wire [15:0] full   = {vlen_r, dat_byte};
   wire [7:0]  vbytes = rem_r - 8'h01;

   // ==========================================================
   // Allocation
   wire [7:0]  tag_cur = (st_r == sdo_pkg::ST_TAG) ? dat_byte : tag_r;
   wire [2:0]  hit_w   = find_slot(1'b0, tag_cur, s_used_r, s_tag_r);
   wire [2:0]  free_w  = find_slot(1'b1, 8'h00, s_used_r, s_tag_r);
   wire        hit     = hit_w[2];
   wire [1:0]  hidx    = hit_w[1:0];
   wire        same    = hit && hidx == ptr_idx_r;
   wire [7:0]  free_bytes = (hit ? {1'b0, s_len_r[hidx]} : 8'h00)
                            + ((open_r && !same) ? {1'b0, cur_len} : 8'h00);
   wire [1:0]  tgt     = hit ? hidx : (open_r ? ptr_idx_r : free_w[1:0]);
   wire        avail   = hit || open_r || free_w[2];
   wire [16:0] need    = 17'(used_r) - 17'(free_bytes) + 17'(full);
   wire        nomem   = full > sdo_pkg::SLOT_LEN_MAX || need > sdo_pkg::CAP_BYTES
                         || !avail;
   wire [15:0] len_sw  = nomem ? sdo_pkg::SW_NOMEM :
                         ({8'h00, vbytes} > full) ? sdo_pkg::SW_WRONGLEN :
                         sdo_pkg::SW_NONE;

   // Events
   wire ev_commit   = len_done && len_sw == sdo_pkg::SW_NONE;
   wire ev_delete   = in_tag && last && tag_sw == sdo_pkg::SW_NONE;
   wire ev_modabort = acc && !is_set && !is_gr && cmd_hdr.mod_ef;
   wire ev_abort    = open_r && (ev_commit || ev_delete || ev_modabort);
   wire wr_en       = dat_valid && st_r == sdo_pkg::ST_VAL;
   wire [6:0] off_inc = off_r + 7'h01;
   wire in_done     = st_r == sdo_pkg::ST_DONE;
   wire ok_res      = res_r == sdo_pkg::SW_OK || res_r == sdo_pkg::SW_MORE
                      || res_r == sdo_pkg::SW_MORE_PRO;

   wire [7:0] used_nxt = ev_commit   ? need[7:0] :
                         ev_delete   ? used_r - free_bytes :
                         (ev_modabort && open_r) ? used_r - {1'b0, cur_len} :
                         used_r;

   // ==========================================================
   // Command sequencer
   always_comb
   begin
      st_nxt  = st_r;
      res_nxt = res_r;
      case (st_r)
         sdo_pkg::ST_IDLE:
         begin
            if (acc && is_set)
            begin
               res_nxt = hdr_sw;
               if (hdr_sw != sdo_pkg::SW_NONE)
                  st_nxt = (cmd_hdr.lc == 8'h00) ? sdo_pkg::ST_DONE : sdo_pkg::ST_SKIP;
               else if (cmd_hdr.lc == 8'h00)
               begin
                  st_nxt  = sdo_pkg::ST_DONE;
                  res_nxt = more_sw;
               end
               else
                  st_nxt = (blk == sdo_pkg::BLK_FIRST) ? sdo_pkg::ST_TAG : sdo_pkg::ST_VAL;
            end
            else if (acc && is_gr)
            begin
               st_nxt  = sdo_pkg::ST_DONE;
               res_nxt = pend_r ? sdo_pkg::SW_OK : sdo_pkg::SW_TECH;
            end
         end
         sdo_pkg::ST_TAG:
         begin
            if (dat_valid)
            begin
               if (tag_sw != sdo_pkg::SW_NONE)
               begin
                  res_nxt = tag_sw;
                  st_nxt  = last ? sdo_pkg::ST_DONE : sdo_pkg::ST_SKIP;
               end
               else if (last)
               begin
                  res_nxt = sdo_pkg::SW_OK;
                  st_nxt  = sdo_pkg::ST_DONE;
               end
               else
                  st_nxt = sdo_pkg::ST_LEN0;
            end
         end
         sdo_pkg::ST_LEN0, sdo_pkg::ST_LEN1, sdo_pkg::ST_LEN2:
         begin
            if (len_bad || (len_more && last))
            begin
               res_nxt = len_bad ? sdo_pkg::SW_BADDATA : sdo_pkg::SW_WRONGLEN;
               st_nxt  = last ? sdo_pkg::ST_DONE : sdo_pkg::ST_SKIP;
            end
            else if (len_more)
               st_nxt = (in_len0 && dat_byte == sdo_pkg::LEN_FORM2) ? sdo_pkg::ST_LEN1
                        : sdo_pkg::ST_LEN2;
            else if (len_done && len_sw != sdo_pkg::SW_NONE)
            begin
               res_nxt = len_sw;
               st_nxt  = last ? sdo_pkg::ST_DONE : sdo_pkg::ST_SKIP;
            end
            else if (len_done && last)
            begin
               res_nxt = (full == 16'h0000) ? sdo_pkg::SW_OK : more_sw;
               st_nxt  = sdo_pkg::ST_DONE;
            end
            else if (len_done)
               st_nxt = sdo_pkg::ST_VAL;
         end
         sdo_pkg::ST_VAL:
         begin
            if (dat_valid && last)
            begin
               res_nxt = (off_inc == cur_len) ? sdo_pkg::SW_OK : more_sw;
               st_nxt  = sdo_pkg::ST_DONE;
            end
         end
         sdo_pkg::ST_SKIP:
         begin
            if (dat_valid && last)
               st_nxt = sdo_pkg::ST_DONE;
         end
         sdo_pkg::ST_DONE:
         begin
            st_nxt = sdo_pkg::ST_IDLE;
         end
         default:
         begin
            st_nxt = sdo_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_r    <= sdo_pkg::ST_IDLE;
         res_r   <= sdo_pkg::SW_NONE;
         ready_r <= 1'b1;
         rem_r   <= 8'h00;
         hdr_r   <= '0;
      end
      else
      begin
         st_r    <= st_nxt;
         res_r   <= res_nxt;
         ready_r <= st_nxt == sdo_pkg::ST_IDLE;
         if (acc)
            hdr_r <= cmd_hdr;
         if (acc)
            rem_r <= cmd_hdr.lc;
         else if (dat_valid && st_r != sdo_pkg::ST_IDLE && st_r != sdo_pkg::ST_DONE)
            rem_r <= rem_r - 8'h01;
      end
   end

   // ==========================================================
   // Transfer context; errors never reach off_r, prev_start_r or prev_lc_r, but tag_r and vlen_r load on error commands too
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tag_r <= 8'h00;
         vlen_r <= 8'h00;
         off_r <= 7'h00;
         prev_start_r <= 7'h00;
         prev_lc_r <= 8'h00;
      end
      else
      begin
         if (in_tag)
            tag_r <= dat_byte;
         if (acc)
            vlen_r <= 8'h00;
         else if (dat_valid && st_r == sdo_pkg::ST_LEN1)
            vlen_r <= dat_byte;
         if (ev_commit)
            off_r <= 7'h00;
         else if (retx_go)
            off_r <= prev_start_r;
         else if (wr_en)
            off_r <= off_inc;
         if (next_go)
         begin
            prev_start_r <= off_r;
            prev_lc_r    <= cmd_hdr.lc;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         open_r <= 1'b0;
         ptr_idx_r <= 2'h0;
         ptr_r <= '0;
         prev_ok_r <= 1'b0;
      end
      else
      begin
         if (ev_commit)
         begin
            open_r    <= 1'b1;
            ptr_idx_r <= tgt;
            ptr_r     <= '{valid: 1'b1, tag: tag_r};
         end
         else if (ev_delete || ev_modabort)
         begin
            open_r <= 1'b0;
            ptr_r  <= '0;
         end
         else if (in_done && set_r && ok_res && open_r && off_r == cur_len)
            open_r <= 1'b0;
         if (in_done)
            prev_ok_r <= set_r && blk_r != sdo_pkg::BLK_FIRST && ok_res;
         else if (acc && !is_set)
            prev_ok_r <= 1'b0;
      end
   end

   // ==========================================================
   // Object table and storage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         used_r <= 8'h00;
         for (int i = 0; i < sdo_pkg::NSLOT; i++)
         begin
            s_used_r[i] <= 1'b0;
            s_tag_r[i]  <= 8'h00;
            s_len_r[i]  <= 7'h00;
         end
      end
      else
      begin
         used_r <= used_nxt;
         if (ev_abort)
            s_used_r[ptr_idx_r] <= 1'b0;
         if (ev_delete && hit)
            s_used_r[hidx] <= 1'b0;
         if (ev_commit)
         begin
            s_used_r[tgt] <= 1'b1;
            s_tag_r[tgt]  <= tag_r;
            s_len_r[tgt]  <= full[6:0];
         end
      end
   end

   // Data bytes carry no reset; an object is only visible once allocated
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem_r[ptr_idx_r][off_r[5:0]] <= dat_byte;
   end

   // ==========================================================
   // Answer and readback
   wire [2:0] rd_w = find_slot(1'b0, rd_tag, s_used_r, s_tag_r);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sw_valid_r <= 1'b0;
         sw_r       <= sdo_pkg::SW_NONE;
         gr_grant_r <= 1'b0;
         pend_r     <= 1'b0;
         rd_hit_r   <= 1'b0;
         rd_len_r   <= 7'h00;
         rd_byte_r  <= 8'h00;
      end
      else
      begin
         sw_valid_r <= in_done;
         if (in_done)
            sw_r <= res_r;
         gr_grant_r <= in_done && !set_r && res_r == sdo_pkg::SW_OK;
         if (resp_offer)
            pend_r <= 1'b1;
         else if (acc)
            pend_r <= 1'b0;
         rd_hit_r  <= rd_w[2];
         rd_len_r  <= s_len_r[rd_w[1:0]];
         rd_byte_r <= mem_r[rd_w[1:0]][rd_idx];
      end
   end

   assign cmd_ready = ready_r;
   assign sw_valid  = sw_valid_r;
   assign sw        = sw_r;
   assign gr_grant  = gr_grant_r;
   assign own_ptr   = ptr_r;
   assign rd_hit    = rd_hit_r;
   assign rd_len    = rd_len_r;
   assign rd_byte   = rd_byte_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_upd_denied: assert property (sw_valid_r && set_r && hdr_r.p1 == sdo_pkg::P1_ZERO
      && !hdr_r.upd_ok |-> sw_r == sdo_pkg::SW_SEC)
      else $error("update denied without security status");
   a_skip_frozen: assert property (st_r == sdo_pkg::ST_SKIP |=> $stable(off_r)
      && $stable(used_r) && $stable(open_r))
      else $error("error command changed transfer context");
   a_nomem_keeps: assert property (len_done && nomem |=> used_r == $past(used_r))
      else $error("failed reservation changed budget");
   a_ok_closes: assert property (sw_valid_r && set_r && sw_r == sdo_pkg::SW_OK
      && blk_r != sdo_pkg::BLK_FIRST |-> !open_r)
      else $error("complete answer with open transfer");
   a_more_open: assert property (sw_valid_r && (sw_r == sdo_pkg::SW_MORE
      || sw_r == sdo_pkg::SW_MORE_PRO) |-> open_r)
      else $error("more-data answer without open transfer");
   a_next_closed: assert property (acc && is_set && blk == sdo_pkg::BLK_NEXT
      && !open_r && cmd_hdr.p1 == sdo_pkg::P1_ZERO && cmd_hdr.upd_ok
      && cmd_hdr.p2[4:0] == sdo_pkg::SFI_CURRENT |=> res_r == sdo_pkg::SW_BADP2)
      else $error("next block after completion not refused");
   a_gr_order: assert property (acc && is_gr && !pend_r |-> ##2 sw_valid_r
      && sw_r == sdo_pkg::SW_TECH)
      else $error("out of order retrieval not refused");
   a_modef_abort: assert property (ev_modabort && open_r |=> !open_r
      && !s_used_r[$past(ptr_idx_r)])
      else $error("aborted object still present");
   a_retx_size: assert property (acc && is_set && blk == sdo_pkg::BLK_RETX
      && hdr_sw == sdo_pkg::SW_COND |=> res_r == sdo_pkg::SW_COND && $stable(open_r))
      else $error("retransmit size mismatch mishandled");
   a_delete_gone: assert property (ev_delete && hit |=> !s_used_r[$past(hidx)])
      else $error("deleted object still present");

   c_delete: cover property (ev_delete);
   c_more: cover property (sw_valid_r && sw_r == sdo_pkg::SW_MORE);
   c_retx: cover property (retx_go);
   c_gr_tech: cover property (sw_valid_r && sw_r == sdo_pkg::SW_TECH);

endmodule

// *** bench/sdo_term.sv ***
// Purpose: Terminal model driving command headers and data bytes.
// Assumes: Requests start 1 ns after a rising edge.
// Notes:   A released data line shows the inverse of its last byte.
`timescale 1ns/1ps
module sdo_term
(
   // Clock
   input  wire logic         clk,
   // Command link
   input  wire logic         cmd_ready,
   output sdo_pkg::sdo_hdr_t cmd_hdr,
   output logic              cmd_valid,
   output logic              dat_valid,
   output logic [7:0]        dat_byte
);
   initial {cmd_valid, dat_valid, cmd_hdr, dat_byte} = '0;
   // Lc always equals the bytes sent, so a retry repeats its length
   task automatic send(input logic [7:0] ins, p1, p2, input logic upd, mef,
                       input logic [7:0] d[$]);
      @(posedge clk) #1;
      cmd_hdr   = '{ins, p1, p2, 8'(d.size()), upd, mef};
      cmd_valid = 1'b1;
      // Ready is read off the edge, so the take edge is the next one
      while (cmd_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
      cmd_valid = 1'b0;
      foreach (d[i])
      begin
         {dat_valid, dat_byte} = {1'b1, d[i]};
         @(posedge clk) #1;
      end
      {dat_valid, dat_byte} = {1'b0, ~dat_byte};
   endtask
endmodule

// *** bench/segmented_data_object_store_tb_top.sv ***
// Purpose: Self-checking bench for the segmented data object store.
// Assumes: One terminal model, one command at a time.
// Notes:   Expected answers queue up and are matched as status words appear.
`timescale 1ns/1ps
module segmented_data_object_store_tb_top;
   logic clk = 0, rst = 1, cmd_valid, cmd_ready, dat_valid, sw_valid, gr_grant, rd_hit;
   logic proactive_pending = 0, resp_offer = 0;
   logic [7:0] dat_byte, rd_byte, rd_tag = 8'h00, a, b;
   logic [5:0] rd_idx = 6'h00;
   logic [6:0] rd_len;
   logic [15:0] sw;
   logic [16:0] exp_q[$];
   logic [7:0] q[$];
   logic [31:0] lfsr = 32'hCFE4;
   int fail_count = 0, checks = 0, cyc = 0;
   sdo_pkg::sdo_hdr_t cmd_hdr;
   sdo_pkg::sdo_ptr_t lock_other = '0, own_ptr;
   localparam logic [7:0] SET = 8'h01, GR = 8'h02, F = 8'h80, N = 8'h00, RX = 8'h40;
   sdo_term u_term (.clk(clk), .cmd_ready(cmd_ready), .cmd_hdr(cmd_hdr),
      .cmd_valid(cmd_valid), .dat_valid(dat_valid), .dat_byte(dat_byte));
   sdo_store #(.INS_SET_DATA(SET), .INS_GET_RESP(GR)) u_dut (.clk(clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_hdr(cmd_hdr), .cmd_ready(cmd_ready),
      .dat_valid(dat_valid), .dat_byte(dat_byte), .lock_other(lock_other),
      .proactive_pending(proactive_pending), .resp_offer(resp_offer), .sw_valid(sw_valid),
      .sw(sw), .gr_grant(gr_grant), .own_ptr(own_ptr), .rd_tag(rd_tag), .rd_idx(rd_idx),
      .rd_hit(rd_hit), .rd_len(rd_len), .rd_byte(rd_byte));
   initial forever #5 clk = ~clk;
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   task automatic check(input logic [16:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic sd(input logic [7:0] ins, p1, p2, input logic upd,
                     input logic [7:0] d[$], input logic [16:0] e);
      exp_q.push_back(e);
      u_term.send(ins, p1, p2, upd, 1'b0, d);
      repeat (8) if (exp_q.size() != 0) @(posedge clk);
      #1;
   endtask
   // Length zero hides the byte, a miss hides length and byte
   task automatic rb(input logic [7:0] t, input logic [5:0] i, input logic [16:0] e);
      {rd_tag, rd_idx} = {t, i};
      repeat (2) @(posedge clk);
      #1 check(rd_hit ? {2'b01, rd_len, rd_len != 0 ? rd_byte : N} : 17'h0, e);
   endtask
   task automatic offer();
      resp_offer = 1;
      @(posedge clk) #1 resp_offer = 0;
   endtask
   always @(negedge clk)
      if (sw_valid === 1'b1)
         check({gr_grant, sw}, exp_q.size() ? exp_q.pop_front() : 17'h1FFFF);
   always @(posedge clk)
      if (++cyc == 3000)
      begin
         fail_count++;
         report_and_stop();
      end
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rst = 0;
      a = rnd();
      b = rnd();
      sd(SET, 0, F, 0, '{8'h10, N}, 17'h06982);
      sd(SET, 1, F, 1, '{8'h10, N}, 17'h06B00);
      sd(SET, 0, F, 1, '{8'h10, 8'h02, a, b}, 17'h09000);
      rb(8'h10, 1, {2'b01, 7'd2, b});
      proactive_pending = 1;
      sd(SET, 0, F, 1, '{8'h20, 8'h03, b}, 17'h063F2);
      proactive_pending = 0;
      sd(SET, 0, N, 1, '{b}, 17'h063F1);
      sd(SET, 0, RX, 1, '{a}, 17'h063F1);
      sd(SET, 0, RX, 1, '{a, b}, 17'h06985);
      sd(SET, 0, N, 1, '{b}, 17'h09000);
      sd(SET, 0, N, 1, '{b}, 17'h06A86);
      rb(8'h20, 1, {2'b01, 7'd3, a});
      sd(SET, 0, F, 1, '{8'h30, 8'h01, a, b}, 17'h06700);
      rb(8'h30, 0, 17'h0);
      sd(SET, 0, F, 1, '{8'hFF, N}, 17'h06A80);
      lock_other = '{1'b1, 8'h50};
      sd(SET, 0, F, 1, '{8'h50, N}, 17'h06985);
      lock_other = '0;
      sd(SET, 0, F, 1, '{8'h10}, 17'h09000);
      rb(8'h10, 0, 17'h0);
      sd(SET, 0, F, 1, '{8'h10}, 17'h09000);
      sd(SET, 0, F, 1, '{8'h70, RX, a}, 17'h063F1);
      sd(SET, 0, F, 1, '{8'h40, N}, 17'h09000);
      rb(8'h70, 0, 17'h0);
      rb(8'h40, 0, 17'h08000);
      check(17'(own_ptr), 17'h00140);
      // A full 64-byte object, so the shared budget really binds below
      q = '{8'h72, RX};
      repeat (64) q.push_back(rnd());
      sd(SET, 0, F, 1, q, 17'h09000);
      rb(8'h72, 6'h3F, {2'b01, 7'h40, q[65]});
      sd(SET, 0, F, 1, '{8'h73, RX, a}, 17'h06A84);
      check(17'(own_ptr), 17'h00172);
      sd(SET, 0, F, 1, '{8'h72}, 17'h09000);
      sd(SET, 0, F, 1, '{8'h73, RX, a}, 17'h063F1);
      u_term.send(8'h0A, 0, 0, 1, 1, '{});
      rb(8'h73, 0, 17'h0);
      check(17'(own_ptr), 17'h0);
      sd(GR, 0, 0, 1, '{}, 17'h06F00);
      offer();
      sd(SET, 0, F, 1, '{8'h10}, 17'h09000);
      sd(GR, 0, 0, 1, '{}, 17'h06F00);
      offer();
      sd(GR, 0, 0, 1, '{}, 17'h19000);
      check(17'(exp_q.size()), 17'h0);
      report_and_stop();
   end
endmodule
